// File: rtl/adcs_pkg.sv
// adcs_pkg: constants and types shared by the conversion sequencer and its timer
// assumes: AHB-Lite word bus, one clock clk_sys at 125 MHz

package adcs_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_RES = 8;     // result registers
    localparam int unsigned RES_W   = 10;    // result width
    localparam int unsigned CHAN_W  = 4;     // channel field width
    localparam int unsigned CNT_W   = 3;     // conversion counter width

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_CTL0      = 8'h0A;  // first control register
    localparam logic [7:0] IDX_CTL1      = 8'h0C;  // second_control_register
    localparam logic [7:0] IDX_STAT      = 8'h0E;  // converter_status_register
    localparam logic [7:0] IDX_RESULT_REGISTER_ZERO     = 8'h10;  // result_register_zero
    localparam logic [7:0] IDX_RESULT_REGISTER_SEVEN     = 8'h1E;  // result_register_seven

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] CTL0_RST      = 8'h03;  // prescaler field reads 3
    localparam logic [6:0] CTL1_RST      = 7'h00;
    localparam int unsigned STAT_SCF_POS = 15;     // sequence_complete_flag
    localparam int unsigned STAT_CTR_POS = 8;      // conversion_counter lsb
    localparam int unsigned STAT_CCF_POS = 0;      // conversion_complete_flags lsb

    // ----------------------------------------------------------------
    // timing: converter clock and conversion length
    // ----------------------------------------------------------------
    localparam logic [2:0] ADC_DIV_LAST  = 3'h7;   // clk_sys / 8 per converter clock
    localparam logic [4:0] CONV_LAST     = 5'h0F;  // 16 converter clocks per conversion

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                continuous_select;       // repeat sequences
        logic                multichannel_select;     // step through a block
        logic                eight_conversion_select; // 8 instead of 4
        logic [CHAN_W-1:0]   channel_select_field;    // input or block
    } adcs_ctl1_t;

    typedef struct packed {
        logic start;   // begin one conversion, restarts a running one
        logic abort;   // drop the running conversion
    } adcs_conv_req_t;

    typedef enum logic {SEQ_IDLE, SEQ_RUN} adcs_seq_state_t;

endpackage : adcs_pkg

// File: rtl/adcs_conv_timer.sv
// adcs_conv_timer: converter clock enable and conversion length counter
// assumes: start and abort are one-cycle pulses on clk_sys

module adcs_conv_timer (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // request from the sequencer
    input  wire adcs_pkg::adcs_conv_req_t req,
    // status back to the sequencer
    output logic                         busy,
    output logic                         done
);
    import adcs_pkg::*;

    logic [2:0] div_reg,  div_next;   // converter clock divider
    logic [4:0] cnt_reg,  cnt_next;   // converter clocks in this conversion
    logic       busy_reg, busy_next;  // conversion running
    logic       done_reg, done_next;  // one-cycle end pulse
    logic       adc_en;               // converter clock enable

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb begin
        adc_en    = (div_reg == ADC_DIV_LAST);
        div_next  = adc_en ? 3'h0 : div_reg + 3'h1;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (req.start) begin
            // start wins over abort so a control write restarts cleanly
            busy_next = 1'b1;
            cnt_next  = 5'h00;
        end else if (req.abort) begin
            busy_next = 1'b0;
            cnt_next  = 5'h00;
        end else if (busy_reg && adc_en) begin
            if (cnt_reg == CONV_LAST) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_reg  <= 3'h0;
            cnt_reg  <= 5'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : adcs_conv_timer

// File: rtl/adcs_sequencer.sv
// adcs_sequencer: conversion sequencer with AHB-Lite register slave
// assumes: analog path returns sar_result on clk_sys when the timer ends
//
// How it works
// - single channel, four conversions, then stop
// - single channel, eight conversions, then stop
// - four inputs from channel bits three and two
// - eight inputs chosen by channel top bit
// - conversion k goes to result k
// - result write sets its complete flag
// - single sequence sets sequence flag at end
// - continuous single channel repeats forever
// - continuous multichannel restarts at block start
// - repeats overwrite results from register zero
// - continuous sets sequence flag after first pass
// - four-bit field selects sixteen mux inputs
// - codes 12..15 are references and test
// - four-block ignores low bits, ascending order
// - eight-block ignores low three bits
// - continuous bit independent of channel mode
// - mode is continuous, multichannel, eight bits
// - control write aborts, clears flags except control 0 when idle
// - reading a result clears its flag
// - counter shows next result index
//
// The AHB-Lite slave port and the register addresses were decided locally.

module adcs_sequencer (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    // ahb-lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic [31:0]                   hrdata,
    output logic                          hresp,
    // analog side
    input  wire logic [adcs_pkg::RES_W-1:0] sar_result,
    output logic [adcs_pkg::CHAN_W-1:0]   mux_sel,
    output logic                          conv_busy
);
    import adcs_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // word address hits a given register index
    function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
        return a[31:2] == {22'h000000, idx};
    endfunction : reg_hit

    // word address hits one of the result registers
    function automatic logic rslt_hit(input logic [31:0] a);
        return (a[31:10] == 22'h000000) && (a[9:2] >= IDX_RESULT_REGISTER_ZERO)
            && (a[9:2] <= IDX_RESULT_REGISTER_SEVEN) && !a[2];
    endfunction : rslt_hit

    // result slot of a result address
    function automatic logic [CNT_W-1:0] rslt_slot(input logic [31:0] a);
        logic [7:0] off;
        off = a[9:2] - IDX_RESULT_REGISTER_ZERO;
        return off[3:1];
    endfunction : rslt_slot

    // mux input for the present conversion
    function automatic logic [CHAN_W-1:0] chan_of(input adcs_ctl1_t c, input logic [CNT_W-1:0] k);
        logic [CHAN_W-1:0] ch;
        ch = c.channel_select_field;
        if (!c.multichannel_select) begin
            chan_of = ch;
        end else if (!c.eight_conversion_select) begin
            chan_of = {ch[3:2], k[1:0]};
        end else begin
            chan_of = {ch[3], k};
        end
    endfunction : chan_of

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    adcs_seq_state_t       state_reg, state_next;  // sequencer state
    logic [7:0]            ctl0_reg,  ctl0_next;   // resolution, sample, prescale
    adcs_ctl1_t            ctl1_reg,  ctl1_next;   // mode and channel
    logic [CNT_W-1:0]      conversion_counter_reg,  conversion_counter_next;   // conversion_counter
    logic                  scf_reg,   scf_next;    // sequence_complete_flag
    logic [NUM_RES-1:0]    ccf_reg,   ccf_next;    // conversion_complete_flags
    logic [RES_W-1:0]      rslt_mem  [NUM_RES];    // result registers
    logic [RES_W-1:0]      rslt_next [NUM_RES];
    logic [CHAN_W-1:0]     mux_reg,   mux_next;    // mux select flop

    // bus state
    logic                  wr_pend_reg, wr_pend_next;  // write data phase due
    logic [31:0]           wr_addr_reg, wr_addr_next;  // its address
    logic [31:0]           rdata_reg,   rdata_next;    // read data flop

    // decoded events
    logic                  acc;           // address phase accepted
    logic                  wr_ctl0;       // data phase write, control 0
    logic                  wr_ctl1;       // data phase write, control 1
    logic [NUM_RES-1:0]    ccf_rd_clr;    // flags cleared by result reads
    logic [2:0]            mode_num;      // conversion mode number
    logic [CNT_W-1:0]      last_idx;      // last result of a pass
    adcs_conv_req_t        conv_req;      // to the timer
    logic                  conv_done;     // from the timer

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    adcs_conv_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .req     (conv_req),
        .busy    (conv_busy),
        .done    (conv_done)
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // zero wait states: every transfer is answered in its first data cycle
    always_comb begin
        acc          = hsel && htrans[1] && hready;
        wr_ctl0      = wr_pend_reg && reg_hit(wr_addr_reg, IDX_CTL0);
        wr_ctl1      = wr_pend_reg && reg_hit(wr_addr_reg, IDX_CTL1);
        ccf_rd_clr   = '0;
        wr_pend_next = acc && hwrite;
        wr_addr_next = acc ? haddr : wr_addr_reg;
        rdata_next   = rdata_reg;
        if (acc && !hwrite) begin
            // unmapped and write-only addresses read as zero
            rdata_next = 32'h0000_0000;
            if (reg_hit(haddr, IDX_CTL0)) begin
                rdata_next = {24'h000000, ctl0_reg};
            end else if (reg_hit(haddr, IDX_CTL1)) begin
                rdata_next = {25'h0000000, ctl1_reg};
            end else if (reg_hit(haddr, IDX_STAT)) begin
                rdata_next[STAT_SCF_POS]                  = scf_reg;
                rdata_next[STAT_CTR_POS +: CNT_W]         = conversion_counter_reg;
                rdata_next[STAT_CCF_POS +: NUM_RES]       = ccf_reg;
            end else if (rslt_hit(haddr)) begin
                rdata_next = {22'h000000, rslt_mem[rslt_slot(haddr)]};
                ccf_rd_clr[rslt_slot(haddr)] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer next values
    // ----------------------------------------------------------------
    always_comb begin
        mode_num   = {ctl1_reg.continuous_select, ctl1_reg.multichannel_select,
                      ctl1_reg.eight_conversion_select};
        last_idx   = mode_num[0] ? 3'h7 : 3'h3;
        state_next = state_reg;
        ctl0_next  = ctl0_reg;
        ctl1_next  = ctl1_reg;
        conversion_counter_next  = conversion_counter_reg;
        scf_next   = scf_reg;
        ccf_next   = ccf_reg & ~ccf_rd_clr;
        rslt_next  = rslt_mem;
        conv_req   = '0;
        if (wr_ctl1) begin
            // new sequence, always from result zero with flags clear
            ctl1_next       = adcs_ctl1_t'(hwdata[6:0]);
            state_next      = SEQ_RUN;
            conversion_counter_next       = '0;
            scf_next        = 1'b0;
            ccf_next        = '0;
            conv_req.start  = 1'b1;
        end else if (wr_ctl0) begin
            // halts until control 1 is written again
            ctl0_next      = hwdata[7:0];
            conv_req.abort = 1'b1;
            state_next     = SEQ_IDLE;
            if (state_reg == SEQ_RUN) begin
                scf_next = 1'b0;
                ccf_next = '0;
            end
        end else if (state_reg == SEQ_RUN && conv_done) begin
            rslt_next[conversion_counter_reg] = sar_result;
            ccf_next[conversion_counter_reg]  = 1'b1;
            if (conversion_counter_reg == last_idx) begin
                // sticky: later passes leave it set, first pass sets it
                scf_next  = 1'b1;
                conversion_counter_next = '0;
                if (mode_num[2]) begin
                    conv_req.start = 1'b1;
                end else begin
                    state_next = SEQ_IDLE;
                end
            end else begin
                conversion_counter_next      = conversion_counter_reg + 3'h1;
                conv_req.start = 1'b1;
            end
        end
        mux_next = chan_of(ctl1_next, conversion_counter_next);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg   <= SEQ_IDLE;
            ctl0_reg    <= CTL0_RST;
            ctl1_reg    <= adcs_ctl1_t'(CTL1_RST);
            conversion_counter_reg    <= '0;
            scf_reg     <= 1'b0;
            ccf_reg     <= '0;
            mux_reg     <= '0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
            rdata_reg   <= 32'h0000_0000;
            for (int i = 0; i < NUM_RES; i++) begin
                rslt_mem[i] <= '0;
            end
        end else begin
            state_reg   <= state_next;
            ctl0_reg    <= ctl0_next;
            ctl1_reg    <= ctl1_next;
            conversion_counter_reg    <= conversion_counter_next;
            scf_reg     <= scf_next;
            ccf_reg     <= ccf_next;
            mux_reg     <= mux_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
            rslt_mem    <= rslt_next;
        end
    end

    // outputs
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;
    assign mux_sel   = mux_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_conv_end;
        state_reg == SEQ_RUN && conv_done && !wr_ctl0 && !wr_ctl1;
    endsequence

    sequence s_pass_end;
        s_conv_end ##0 conversion_counter_reg == last_idx;
    endsequence

    AST_RESULT_SLOT: assert property (s_conv_end |=> rslt_mem[$past(conversion_counter_reg)] == $past(sar_result))
        else $error("result not stored in counter slot");
    AST_FLAG_SET: assert property (s_conv_end |=> ccf_reg[$past(conversion_counter_reg)])
        else $error("complete flag not set");
    AST_SINGLE_STOP: assert property (s_pass_end ##0 !mode_num[2] |=> state_reg == SEQ_IDLE && scf_reg)
        else $error("single sequence did not stop");
    AST_REPEAT: assert property (s_pass_end ##0 mode_num[2]
                                 |=> state_reg == SEQ_RUN && conversion_counter_reg == 3'h0 && scf_reg)
        else $error("continuous pass did not wrap");
    AST_CTL1_START: assert property (wr_ctl1 |=> conversion_counter_reg == 3'h0 && ccf_reg == '0 && !scf_reg
                                     ##[1:140] conv_done)
        else $error("control write did not restart");
    AST_MUX_ONE: assert property (!ctl1_reg.multichannel_select |-> mux_sel == ctl1_reg.channel_select_field)
        else $error("single channel select wrong");
    AST_MUX_FOUR: assert property (ctl1_reg.multichannel_select && !ctl1_reg.eight_conversion_select
                                   |-> mux_sel == {ctl1_reg.channel_select_field[3:2], conversion_counter_reg[1:0]})
        else $error("four-block select wrong");
    AST_MUX_EIGHT: assert property (ctl1_reg.multichannel_select && ctl1_reg.eight_conversion_select
                                    |-> mux_sel == {ctl1_reg.channel_select_field[3], conversion_counter_reg})
        else $error("eight-block select wrong");
    AST_IDLE_HOLD: assert property (state_reg == SEQ_IDLE && !wr_ctl1 |=> state_reg == SEQ_IDLE
                                    && $stable(conversion_counter_reg) && !conv_busy)
        else $error("idle sequencer moved");
    AST_READ_CLR: assert property (|ccf_rd_clr && !wr_ctl1 && !wr_ctl0 && !conv_done
                                   |=> (ccf_reg & $past(ccf_rd_clr)) == '0)
        else $error("read did not clear flag");

endmodule : adcs_sequencer

// File: sim/adc_conversion_sequencer_test.sv
// adc_conversion_sequencer_test: self-checking bench for the conversion sequencer
// assumes: bench is the only ahb-lite master, sar_result echoes {salt, mux_sel}

module adc_conversion_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adcs_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int LIMIT = 60000;              // run needs about 22k cycles
    logic                clk_sys;              // 125 MHz system clock
    logic                rst;                  // synchronous, active high
    logic                hsel;                 // ahb-lite master side
    logic                hwrite;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic                hreadyout;            // one slave, so this is hready
    logic                hresp;
    logic [RES_W-1:0]    sar_result;           // analog path stand-in
    logic [CHAN_W-1:0]   mux_sel;
    logic                conv_busy;
    logic [5:0]          salt;                 // random upper result bits
    int                  num_errors;
    int                  num_checks;
    int                  cycles;

    adcs_sequencer u_dut (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hreadyout  (hreadyout),
        .hrdata     (hrdata),
        .hresp      (hresp),
        .sar_result (sar_result),
        .mux_sel    (mux_sel),
        .conv_busy  (conv_busy)
    );

    // ----------------------------------------------------------------
    // clock, analog echo and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // result carries the input it was taken from, so order is visible
    always @(posedge clk_sys) begin
        sar_result <= {salt, mux_sel};
    end

    // a stuck handshake or sequence ends here instead of hanging
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] adr(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};            // byte address is four times index
    endfunction : adr

    // input expected for conversion k of a sequence
    function automatic logic [3:0] exp_chan(input logic [2:0] mode, input logic [3:0] ch, input int k);
        if (!mode[1]) return ch;
        if (mode[0]) return {ch[3], 3'(k)};
        return {ch[3:2], 2'(k)};
    endfunction : exp_chan

    // wait for the edge at which hready is sampled high
    task automatic wait_rdy();
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    task automatic bus_rd(input logic [31:0] addr, output logic [31:0] data);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr  <= addr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        wait_rdy();
        data = hrdata;
    endtask : bus_rd

    task automatic bus_wr(input logic [31:0] addr, input logic [31:0] data);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr  <= addr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= data;
        wait_rdy();
    endtask : bus_wr

    task automatic chk_results(input logic [2:0] mode, input logic [3:0] ch, input logic [5:0] sv);
        logic [31:0] rd;
        for (int k = 0; k <= (mode[0] ? 7 : 3); k++) begin
            bus_rd(adr(IDX_RESULT_REGISTER_ZERO + 8'(2 * k)), rd);
            chk(rd, {22'h0, sv, exp_chan(mode, ch, k)});
        end
    endtask : chk_results

    // one full sequence in the given mode, checked from start to end
    task automatic run_mode(input logic [2:0] mode, input logic [3:0] ch);
        logic [31:0] st;
        logic [31:0] rd;
        logic [7:0]  mask;
        logic [5:0]  sv;
        int          c;
        mask = mode[0] ? 8'hFF : 8'h0F;
        sv   = 6'($urandom);
        salt <= sv;
        bus_wr(adr(IDX_CTL1), {25'h0, mode, ch});
        bus_rd(adr(IDX_STAT), st);
        chk(st, 32'h0);
        bus_rd(adr(IDX_CTL1), rd);
        chk(rd, {25'h0, mode, ch});
        for (int n = 0; n < 3000 && st[15] !== 1'b1; n++) begin
            bus_rd(adr(IDX_STAT), st);
            c = $countones(st[7:0]);
            if (st[15] !== 1'b1) chk({21'h0, st[10:0]}, {21'h0, 3'(c), (8'h01 << c) - 8'h01});
        end
        chk(st, 32'h8000 | {24'h0, mask});
        chk_results(mode, ch, sv);
        bus_rd(adr(IDX_STAT), st);
        chk(st, 32'h8000);
        if (!mode[2]) begin
            // a finished single sequence must stay parked
            repeat (200) @(posedge clk_sys);
            bus_rd(adr(IDX_STAT), st);
            chk(st, 32'h8000);
            chk({31'h0, conv_busy}, 32'h0);
        end else begin
            // new salt must show in every register after further passes
            sv   = 6'($urandom);
            salt <= sv;
            repeat ((mode[0] ? 10 : 6) * 128) @(posedge clk_sys);
            // look between edges; busy drops for the one cycle between two conversions
            @(negedge clk_sys);
            if (conv_busy !== 1'b1) @(negedge clk_sys);
            chk({31'h0, conv_busy}, 32'h1);
            @(posedge clk_sys);
            chk_results(mode, ch, sv);
            bus_wr(adr(IDX_CTL0), 32'h3);
            bus_rd(adr(IDX_STAT), st);
            chk({23'h0, st[15], st[7:0]}, 32'h0);
            chk({31'h0, conv_busy}, 32'h0);
        end
    endtask : run_mode

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        rst        = 1'b1;
        hsel       = 1'b0;
        hwrite     = 1'b0;
        htrans     = 2'b00;
        hsize      = 3'h2;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        salt       = 6'h00;
        sar_result = '0;
        num_errors = 0;
        num_checks = 0;
        cycles     = 0;
        void'($urandom(41));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // reset values, read-only status and an unmapped word
        chk({30'h0, hreadyout, hresp}, 32'h2);
        bus_wr(adr(IDX_STAT), 32'hFFFF);
        bus_wr(adr(IDX_RESULT_REGISTER_ZERO), 32'h3FF);
        bus_rd(adr(IDX_CTL0), rd);
        chk(rd, 32'h3);
        bus_rd(adr(IDX_CTL1), rd);
        chk(rd, 32'h0);
        bus_rd(adr(IDX_STAT), rd);
        chk(rd, 32'h0);
        bus_rd(adr(IDX_RESULT_REGISTER_ZERO), rd);
        chk(rd, 32'h0);
        bus_rd(adr(8'h11), rd);
        chk(rd, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        // every mode twice: the upper codes first, then random fields
        for (int i = 0; i < 16; i++) begin
            run_mode(3'(i), (i < 8) ? 4'(15 - i) : 4'($urandom));
        end
        end_sim();
    end

endmodule : adc_conversion_sequencer_test
